// File: rtl/mdc_pkg.sv
// Package for the motor drive control and fault response block.
// Assumes one 100 MHz clock and a synchronous active-high reset.
package mdc_pkg;
  // ----------------------------------------
  // Motor latch field layout
  // ----------------------------------------
  localparam int LATCH_W      = 16;
  localparam int CUR_A_LSB    = 11;
  localparam int CUR_A_MSB    = 14;
  localparam int PHASE_A_BIT  = 15;
  localparam int PHASE_B_BIT  = 8;
  localparam logic [15:0] LATCH_RESET = 16'h0000;
  // Extended setup latch: reset mask bit position
  localparam int RST_MASK_BIT = 0;
  localparam logic [15:0] SETUP_RESET = 16'h0000;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_MHZ       = 100;
  localparam int LPULSE_MS     = 40;
  localparam int LPULSE_CYC    = LPULSE_MS * 1000 * CLK_MHZ;
  localparam int PULSE_HALF_US = 625;
  localparam int PULSE_HALF_CYC = PULSE_HALF_US * CLK_MHZ / 1000;
  localparam int STAGGER_US    = 10;
  localparam int STAGGER_CYC   = STAGGER_US * CLK_MHZ;
  // Three-level converter select
  typedef enum logic [1:0] {MDC_SEL_LOW, MDC_SEL_MID, MDC_SEL_HIGH} mdc_sel_t;
endpackage

// File: rtl/mdc_sync.sv
// Two-flop synchroniser for asynchronous detector levels.
// Assumes inputs are quiet compared to the clock.
`timescale 1ns/1ps
module mdc_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      meta     <= '0;
      sync_out <= '0;
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end
endmodule

// File: rtl/mdc_top.sv
// Motor bridge control, power-save handling, converter start and faults.
// Assumes the host drives pins synchronous to clk; detectors are async.
`timescale 1ns/1ps
module mdc_top #(
  parameter int LPULSE_CYCLES = mdc_pkg::LPULSE_CYC,
  parameter int HALF_CYCLES   = mdc_pkg::PULSE_HALF_CYC,
  parameter int STAGGER       = mdc_pkg::STAGGER_CYC
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        power_save,
  input  wire logic        strobe,
  input  wire logic        strobe_data,
  input  wire logic [15:0] shift_word,
  input  wire logic        dc_mode,
  input  wire logic [1:0]  phase_in,
  input  wire logic [1:0]  enable_in,
  input  wire logic [1:0]  conv_select,
  input  wire logic [2:0]  converter_undervoltage_stop,
  input  wire logic        motor_overcurrent_stop,
  input  wire logic        thermal_shutdown,
  output logic [3:0]       chan_a_current_code,
  output logic [1:0]       out_pos,
  output logic [1:0]       out_neg,
  output logic [1:0]       bridge_on,
  output logic             motor_run,
  output logic [2:0]       conv_en,
  output logic             external_reset_out
);
  initial begin
    if (LPULSE_CYCLES < 2 || HALF_CYCLES < 1 || STAGGER < 1 || HALF_CYCLES * 2 > LPULSE_CYCLES)
      $error("mdc_top: bad timing parameters");
  end

  // ----------------------------------------
  // Detector synchronisation
  // ----------------------------------------
  logic [4:0] det_s;
  mdc_sync #(.W(5)) u_sync (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .async_in ({thermal_shutdown, motor_overcurrent_stop, converter_undervoltage_stop}),
    .sync_out (det_s)
  );
  logic [2:0] uv_s;
  logic       oc_s;
  logic       ot_s;
  assign uv_s = det_s[2:0];
  assign oc_s = det_s[3];
  assign ot_s = det_s[4];

  // ----------------------------------------
  // Edge detection
  // ----------------------------------------
  logic ps_q;
  logic strobe_q;
  logic ps_edge;
  logic ps_rise;
  logic ps_fall;
  logic strobe_rise;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      // Track the pin in reset so a high level is not seen as an edge
      ps_q     <= power_save;
      strobe_q <= 1'b0;
    end else begin
      ps_q     <= power_save;
      strobe_q <= strobe;
    end
  end
  assign ps_edge     = ps_q ^ power_save;
  assign ps_rise     = ~ps_q & power_save;
  assign ps_fall     = ps_q & ~power_save;
  assign strobe_rise = ~strobe_q & strobe;

  // ----------------------------------------
  // Latches
  // ----------------------------------------
  logic [15:0] motor_drive_latch;
  logic [15:0] init_setup;
  logic [15:0] ext_setup;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      motor_drive_latch <= mdc_pkg::LATCH_RESET;
    end else if (ps_edge) begin
      motor_drive_latch <= mdc_pkg::LATCH_RESET;
    end else if (strobe_rise && power_save) begin
      motor_drive_latch <= shift_word;
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      init_setup <= mdc_pkg::SETUP_RESET;
      ext_setup  <= mdc_pkg::SETUP_RESET;
    end else if (strobe_rise && !power_save) begin
      if (strobe_data) begin
        ext_setup <= shift_word;
      end else begin
        init_setup <= shift_word;
      end
    end
  end
  logic rst_mask;
  assign rst_mask = ext_setup[mdc_pkg::RST_MASK_BIT];

  // ----------------------------------------
  // Fault state
  // ----------------------------------------
  logic       shutdown;
  logic       motor_off;
  logic       ps_seen_low;
  logic [2:0] conv_off;
  logic [2:0] conv_low_seen;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      shutdown <= 1'b0;
    end else if (ot_s || (!rst_mask && |uv_s)) begin
      shutdown <= 1'b1;
    end
  end
  // Overcurrent stop clears only after high, low, high
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      motor_off   <= 1'b0;
      ps_seen_low <= 1'b0;
    end else if (oc_s) begin
      motor_off   <= 1'b1;
      ps_seen_low <= 1'b0;
    end else if (motor_off && ps_fall) begin
      ps_seen_low <= 1'b1;
    end else if (motor_off && ps_seen_low && ps_rise) begin
      motor_off   <= 1'b0;
      ps_seen_low <= 1'b0;
    end
  end
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_conv
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          conv_off[g]      <= 1'b0;
          conv_low_seen[g] <= 1'b0;
        end else if (uv_s[g] && rst_mask) begin
          conv_off[g]      <= 1'b1;
          conv_low_seen[g] <= ~power_save;
        end else if (conv_off[g] && ps_fall) begin
          conv_low_seen[g] <= 1'b1;
        end else if (conv_off[g] && conv_low_seen[g] && ps_rise) begin
          conv_off[g]      <= 1'b0;
          conv_low_seen[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Converter start sequencing
  // ----------------------------------------
  logic [31:0] stag_cnt;
  logic [2:0]  conv_start;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      stag_cnt   <= '0;
      conv_start <= 3'h0;
    end else begin
      if (conv_select != 2'(mdc_pkg::MDC_SEL_LOW) && stag_cnt < 32'(STAGGER)) begin
        stag_cnt <= stag_cnt + 32'h1;
      end
      case (conv_select)
        2'(mdc_pkg::MDC_SEL_MID): conv_start <= {1'b0, stag_cnt >= 32'(STAGGER), 1'b1} | conv_start;
        2'(mdc_pkg::MDC_SEL_HIGH): conv_start <= {stag_cnt >= 32'(STAGGER), 1'b0, 1'b1} | conv_start;
        default: conv_start <= conv_start;
      endcase
    end
  end
  // Bit order: [0]=B, [1]=A, [2]=C
  logic [2:0] conv_abc;
  assign conv_abc = {conv_start[2], conv_start[0], conv_start[1]};
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      conv_en <= 3'h0;
    end else begin
      conv_en <= shutdown ? 3'h0 : (conv_abc & ~conv_off);
    end
  end

  // ----------------------------------------
  // Reset output pulse train
  // ----------------------------------------
  logic [31:0] lp_cnt;
  logic [31:0] half_cnt;
  logic        lp_level;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lp_cnt   <= '0;
      half_cnt <= '0;
      lp_level <= 1'b1;
    end else if (oc_s && !motor_off) begin
      lp_cnt   <= 32'(LPULSE_CYCLES);
      half_cnt <= '0;
      lp_level <= 1'b0;
    end else if (lp_cnt != 32'h0) begin
      lp_cnt <= lp_cnt - 32'h1;
      if (lp_cnt == 32'h1) begin
        lp_level <= 1'b1;
        half_cnt <= '0;
      end else if (half_cnt == 32'(HALF_CYCLES - 1)) begin
        half_cnt <= '0;
        lp_level <= ~lp_level;
      end else begin
        half_cnt <= half_cnt + 32'h1;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      external_reset_out <= 1'b0;
    end else begin
      external_reset_out <= ~shutdown & lp_level;
    end
  end

  // ----------------------------------------
  // Bridge outputs
  // ----------------------------------------
  // Direct phase path is combinational so host PWM edges are not delayed
  assign motor_run           = power_save & ~motor_off & ~shutdown;
  assign chan_a_current_code = motor_drive_latch[mdc_pkg::CUR_A_MSB:mdc_pkg::CUR_A_LSB];
  logic [1:0] pol;
  assign pol = dc_mode ? phase_in
             : {motor_drive_latch[mdc_pkg::PHASE_B_BIT], motor_drive_latch[mdc_pkg::PHASE_A_BIT]};
  assign bridge_on = {2{motor_run}} & (dc_mode ? enable_in : 2'h3);
  assign out_pos   = bridge_on & pol;
  assign out_neg   = bridge_on & ~pol;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  AST_LATCH_CLEAR: assert property (@(posedge clk) disable iff (sys_rst)
    ps_edge |=> motor_drive_latch == 16'h0000) else $error("latch not cleared");
  AST_CODE_MAP: assert property (@(posedge clk) disable iff (sys_rst)
    (strobe_rise && power_save && !ps_edge) |=> chan_a_current_code == $past(shift_word[14:11])) else $error("bad current code");
  AST_DC_POL: assert property (@(posedge clk) disable iff (sys_rst)
    (dc_mode && bridge_on[0] && !phase_in[0]) |-> (!out_pos[0] && out_neg[0])) else $error("bad polarity");
  AST_EN_OFF: assert property (@(posedge clk) disable iff (sys_rst)
    (dc_mode && !enable_in[1]) |-> (out_pos[1] == 1'b0 && out_neg[1] == 1'b0)) else $error("bridge not off");
  AST_OT_HOLD: assert property (@(posedge clk) disable iff (sys_rst)
    ot_s |=> ##1 (!external_reset_out && conv_en == 3'h0)) else $error("no shutdown");
  AST_OC_PULSE: assert property (@(posedge clk) disable iff (sys_rst)
    (oc_s && !motor_off && !shutdown) |=> ##1 !external_reset_out) else $error("no low pulse");
  AST_OC_MOTOR: assert property (@(posedge clk) disable iff (sys_rst)
    oc_s |=> !motor_run) else $error("motor not stopped");
  AST_MASK0_UV: assert property (@(posedge clk) disable iff (sys_rst)
    (!rst_mask && |uv_s) |=> shutdown) else $error("mask0 no shutdown");
  AST_MASK1_UV: assert property (@(posedge clk) disable iff (sys_rst)
    (rst_mask && uv_s[0] && !ot_s && !shutdown) |=> (!shutdown && conv_off[0])) else $error("mask1 wrong");
  AST_SLEEP_LOAD: assert property (@(posedge clk) disable iff (sys_rst)
    (strobe_rise && !power_save && !strobe_data) |=> init_setup == $past(shift_word)) else $error("no setup load");
endmodule

// File: verification/mdc_host_model.sv
// Host controller model driving the serial-side control pins.
// Assumes one clk; tasks are called by the bench just after a rising edge.
`timescale 1ns/1ps
module mdc_host_model (
  input  wire logic        clk,
  output logic             power_save,
  output logic             strobe,
  output logic             strobe_data,
  output logic [15:0]      shift_word
);
  // ----------------------------------------
  // Pin defaults
  // ----------------------------------------
  initial begin
    power_save  = 1'b0;
    strobe      = 1'b0;
    strobe_data = 1'b0;
    shift_word  = 16'h0000;
  end
  // ----------------------------------------
  // Pin sequences
  // ----------------------------------------
  // Strobe low for a full edge so every call is a fresh rise
  task automatic load(input logic d, input logic [15:0] w);
    @(posedge clk);
    #1 strobe = 1'b1;
    strobe_data = d;
    shift_word  = w;
    @(posedge clk);
    #1 strobe = 1'b0;
    // Word scrambled so a stale value cannot pass for a load
    shift_word = ~w;
  endtask
  task automatic sleep_to(input logic v);
    @(posedge clk);
    #1 power_save = v;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic wake_cycle();
    sleep_to(1'b0);
    sleep_to(1'b1);
  endtask
endmodule

// File: verification/tb.sv
// Self-checking bench for the motor drive control and fault block.
// Assumes the host model drives power-save and strobe pins.
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin mismatches++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb;
  logic        clk         = 1'b0;
  logic        sys_rst     = 1'b1;
  logic        dc_mode     = 1'b0;
  logic [1:0]  phase_in    = 2'b00;
  logic [1:0]  enable_in   = 2'b00;
  logic [1:0]  conv_select = 2'b01;
  logic [2:0]  uv          = 3'b000;
  logic        oc          = 1'b0;
  logic        ot          = 1'b0;
  logic        power_save;
  logic        strobe;
  logic        strobe_data;
  logic [15:0] shift_word;
  logic [3:0]  code;
  logic [1:0]  out_pos;
  logic [1:0]  out_neg;
  logic [1:0]  bridge_on;
  logic        motor_run;
  logic        rst_out;
  logic [2:0]  conv_en;
  int          mismatches   = 0;
  int          total_checks = 0;
  int          cycles       = 0;
  int          lows;
  // ----------------------------------------
  // Clock, timeout and instances
  // ----------------------------------------
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      mismatches++;
      report_and_stop();
    end
  end
  // Short counts keep the pulse train inside a few hundred cycles
  mdc_top #(.LPULSE_CYCLES(200), .HALF_CYCLES(5), .STAGGER(10)) i_mdc_top (
    .clk(clk), .sys_rst(sys_rst), .power_save(power_save), .strobe(strobe), .strobe_data(strobe_data),
    .shift_word(shift_word), .dc_mode(dc_mode), .phase_in(phase_in), .enable_in(enable_in),
    .conv_select(conv_select), .converter_undervoltage_stop(uv), .motor_overcurrent_stop(oc),
    .thermal_shutdown(ot), .chan_a_current_code(code), .out_pos(out_pos), .out_neg(out_neg),
    .bridge_on(bridge_on), .motor_run(motor_run), .conv_en(conv_en), .external_reset_out(rst_out));
  mdc_host_model i_mdc_host_model (
    .clk(clk), .power_save(power_save), .strobe(strobe), .strobe_data(strobe_data), .shift_word(shift_word));
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic t_start(input logic [1:0] sel, input logic [2:0] first, input logic [2:0] both);
    conv_select = sel;
    sys_rst = 1'b1;
    repeat (16) @(posedge clk);
    #1 sys_rst = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    `CHK("conv_first", first, conv_en)
    repeat (20) @(posedge clk);
    #1;
    `CHK("conv_start", both, conv_en)
    `CHK("latch_init", 4'h0, code)
    `CHK("rst_release", 1'b1, rst_out)
  endtask
  task automatic t_latch();
    i_mdc_host_model.load(1'b1, 16'h0001);
    i_mdc_host_model.load(1'b0, 16'hF8F0);
    `CHK("setup_only", 4'h0, code)
    `CHK("sleep_mode", 1'b0, motor_run)
    i_mdc_host_model.sleep_to(1'b1);
    i_mdc_host_model.load(1'b0, 16'hF8F0);
    `CHK("code_a", 4'hF, code)
    `CHK("pos_a", 2'b01, out_pos)
    `CHK("neg_a", 2'b10, out_neg)
    `CHK("run_mode", 1'b1, motor_run)
    i_mdc_host_model.load(1'b0, 16'h0970);
    `CHK("code_b", 4'h1, code)
    `CHK("pos_b", 2'b10, out_pos)
    `CHK("neg_b", 2'b01, out_neg)
    i_mdc_host_model.sleep_to(1'b0);
    `CHK("edge_clear", 4'h0, code)
  endtask
  task automatic t_uv_mask1();
    uv = 3'b001;
    repeat (8) @(posedge clk);
    #1;
    `CHK("uv_a_conv", 3'b010, conv_en)
    `CHK("uv_a_rst", 1'b1, rst_out)
    uv = 3'b000;
    // Let the synchronised fault drop; a set outranks a restart
    repeat (4) @(posedge clk);
    i_mdc_host_model.sleep_to(1'b1);
    repeat (4) @(posedge clk);
    #1;
    `CHK("restart_a", 3'b011, conv_en)
    uv = 3'b010;
    repeat (8) @(posedge clk);
    #1;
    `CHK("uv_b_conv", 3'b001, conv_en)
    `CHK("uv_b_motor", 1'b1, motor_run)
    `CHK("uv_b_rst", 1'b1, rst_out)
    uv = 3'b000;
    repeat (4) @(posedge clk);
    i_mdc_host_model.wake_cycle();
    repeat (4) @(posedge clk);
    #1;
    `CHK("restart_b", 3'b011, conv_en)
  endtask
  task automatic t_dc();
    dc_mode = 1'b1;
    // Every enable pair against every phase pair
    for (int e = 0; e < 4; e++) begin
      enable_in = e[1:0];
      for (int p = 0; p < 4; p++) begin
        phase_in = p[1:0];
        #2;
        `CHK("dc_on", e[1:0], bridge_on)
        `CHK("dc_pos", p[1:0] & e[1:0], out_pos)
        `CHK("dc_neg", ~p[1:0] & e[1:0], out_neg)
        `CHK("dc_off", 2'b00, (out_pos | out_neg) & ~e[1:0])
        @(posedge clk);
        #1;
      end
    end
    dc_mode = 1'b0;
  endtask
  task automatic t_oc();
    oc = 1'b1;
    repeat (8) @(posedge clk);
    #1;
    `CHK("oc_motor", 1'b0, motor_run)
    `CHK("oc_conv", 3'b011, conv_en)
    oc = 1'b0;
    lows = 0;
    repeat (260) begin
      @(posedge clk);
      #1 lows += (rst_out === 1'b0);
    end
    // Half the train is low; a held-low or missing pulse misses this band
    `CHK("oc_pulse", 1'b1, lows > 80 && lows < 120)
    `CHK("oc_rst_end", 1'b1, rst_out)
    `CHK("oc_held", 1'b0, motor_run)
    i_mdc_host_model.wake_cycle();
    `CHK("oc_recover", 1'b1, motor_run)
  endtask
  task automatic t_shutdown(input logic th);
    ot = th;
    uv = th ? 3'b000 : 3'b100;
    repeat (8) @(posedge clk);
    #1;
    ot = 1'b0;
    uv = 3'b000;
    i_mdc_host_model.wake_cycle();
    `CHK("sd_conv", 3'b000, conv_en)
    `CHK("sd_motor", 1'b0, motor_run)
    `CHK("sd_rst", 1'b0, rst_out)
  endtask
  initial begin
    t_start(2'b01, 3'b010, 3'b011);
    t_latch();
    t_uv_mask1();
    t_dc();
    t_oc();
    t_shutdown(1'b1);
    t_start(2'b10, 3'b010, 3'b110);
    t_shutdown(1'b0);
    t_start(2'b00, 3'b000, 3'b000);
    report_and_stop();
  end
endmodule
